// ===== hdl/wire_cfg_defines.vh
// Shared constants for the single-wire configuration port.
// Assumes a 50 MHz system clock; times are in ns and counts derive from them.
`ifndef WIRE_CFG_DEFINES_VH
`define WIRE_CFG_DEFINES_VH

// Clock period in ns.
`define CLK_PERIOD_NS       20
// Function command codes.
`define CMD_WRITE_NDIV      8'h01
`define CMD_READ_NDIV       8'hA1
`define CMD_WRITE_OPTION    8'h02
`define CMD_READ_OPTION     8'hA2
// Field widths.
`define CMD_BITS            8
`define DATA_BITS           9
// Register reset values.
`define NDIV_RESET          9'h000
`define OPTION_RESET        9'h034
// Option register field positions.
`define OPT_N_COUNT_BYPASS  0
`define OPT_PRESCALER_SKIP  3
// Least low time that counts as a master reset pulse, in ns. It must stay
// well above the longest write-zero low time, which outlasts the slot delay.
`define RESET_MIN_NS        480000
`define RESET_MIN_CYC       ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Wait after the reset pulse ends before presence, in ns.
`define PRES_WAIT_NS        30000
`define PRES_WAIT_CYC       (`PRES_WAIT_NS / `CLK_PERIOD_NS)
// Length of the presence pulse, in ns.
`define PRES_LEN_NS         120000
`define PRES_LEN_CYC        (`PRES_LEN_NS / `CLK_PERIOD_NS)
// Internal slot delay: sampling point and read-zero hold time, in ns.
`define SLOT_DELAY_NS       30000
`define SLOT_DELAY_CYC      (`SLOT_DELAY_NS / `CLK_PERIOD_NS)

`endif

// ===== hdl/slot_timer.v
// Down-counter that measures one delay from a start pulse.
// Assumes start is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module slot_timer #(
  parameter WIDTH = 16
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             rst_n,
  // Control.
  input  wire             start,
  input  wire [WIDTH-1:0] length,
  // Status.
  output reg              busy,
  output reg              done
);

  // Remaining cycles of the running delay.
  reg [WIDTH-1:0] remain;

  // Load on start; a restart simply reloads, so a late edge extends the delay.
  always @(posedge clk) begin
    if (!rst_n) begin
      remain <= {WIDTH{1'b0}};
      busy   <= 1'b0;
      done   <= 1'b0;
    end else if (start) begin
      remain <= length;
      busy   <= 1'b1;
      done   <= 1'b0;
    end else if (busy && remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
      busy   <= 1'b0;
      done   <= 1'b1;
    end else begin
      remain <= busy ? remain - {{(WIDTH-1){1'b0}}, 1'b1} : remain;
      done   <= 1'b0;
    end
  end

endmodule // slot_timer

`default_nettype wire

// ===== hdl/single_wire_config_port.v
// Single-wire configuration port: two 9-bit setting registers behind one
// open-drain data line. Assumes line_in is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "wire_cfg_defines.vh"

module single_wire_config_port #(
  parameter RESET_MIN_CYC = `RESET_MIN_CYC,
  parameter PRES_WAIT_CYC = `PRES_WAIT_CYC,
  parameter PRES_LEN_CYC  = `PRES_LEN_CYC,
  parameter SLOT_CYC      = `SLOT_DELAY_CYC
) (
  // Clock and reset.
  input  wire       clk,
  input  wire       rst_n,
  // Open-drain data line.
  input  wire       line_in,
  output reg        line_out,
  output reg        line_oe,
  // Register contents for the divider datapath.
  output reg  [8:0] n_divisor_setting,
  output reg  [8:0] option_setting,
  // Status.
  output reg        write_done,
  output reg        bad_command
);

  // One-hot states.
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_WAIT  = 6'h02;
  localparam [5:0] ST_PRES  = 6'h04;
  localparam [5:0] ST_CMD   = 6'h08;
  localparam [5:0] ST_DATA  = 6'h10;
  localparam [5:0] ST_DONE  = 6'h20;

  // Last bit index of each field, kept 32 bits wide and sliced where compared.
  localparam [31:0] CMD_LAST_W  = `CMD_BITS - 1;
  localparam [31:0] DATA_LAST_W = `DATA_BITS - 1;

  reg  [5:0]  state;          // Current state.
  reg         line_q;         // Line level one cycle ago.
  reg  [15:0] low_cnt;        // Length of the current low period.
  reg  [17:0] wait_cnt;       // Presence wait and pulse timer.
  reg  [3:0]  bit_cnt;        // Bits moved in the current field.
  reg  [7:0]  cmd;            // Command shift register.
  reg  [8:0]  data;           // Data shift register.
  reg         read_dir;       // Data phase sends to the master.
  reg         sel_option;     // Data phase targets the option register.
  wire        fall;           // Falling edge of the line.
  wire        rise;           // Rising edge of the line.
  wire        slot_busy;      // Slot delay running.
  wire        slot_done;      // Slot delay expired.
  wire        reset_seen;     // Low long enough to be a reset pulse.
  reg         slot_go;        // Starts the slot delay.
  reg  [8:0]  next_data;      // Data register after a sampled bit.

  assign fall       = line_q & ~line_in;
  assign rise       = ~line_q & line_in;
  assign reset_seen = rise && (low_cnt >= RESET_MIN_CYC[15:0]);

  // The slot delay only runs inside the command and data phases.
  always @* begin
    slot_go = fall && (state == ST_CMD || state == ST_DATA);
  end

  // The sampled bit enters at the top so nine bits land lsb first.
  always @* begin
    next_data = {line_in, data[8:1]};
  end

  // Delay circuit shared by write sampling and read-zero hold.
  slot_timer #(
    .WIDTH (16)
  ) u_slot_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (slot_go),
    .length (SLOT_CYC[15:0]),
    .busy   (slot_busy),
    .done   (slot_done)
  );

  // Edge detector and low-period counter; a long low aborts any transaction.
  always @(posedge clk) begin
    if (!rst_n) begin
      line_q  <= 1'b1;
      low_cnt <= 16'h0000;
    end else begin
      line_q  <= line_in;
      // The device's own presence or read-zero drive never counts as a
      // master reset pulse, or the end of presence would restart the link.
      if (line_in || line_oe)
        low_cnt <= 16'h0000;
      else if (low_cnt != 16'hFFFF)
        low_cnt <= low_cnt + 16'h0001;
    end
  end

  // Transaction sequencer.
  always @(posedge clk) begin
    if (!rst_n) begin
      state             <= ST_IDLE;
      wait_cnt          <= 18'h00000;
      bit_cnt           <= 4'h0;
      cmd               <= 8'h00;
      data              <= 9'h000;
      read_dir          <= 1'b0;
      sel_option        <= 1'b0;
      line_out          <= 1'b0;
      line_oe           <= 1'b0;
      n_divisor_setting <= `NDIV_RESET;
      option_setting    <= `OPTION_RESET;
      write_done        <= 1'b0;
      bad_command       <= 1'b0;
    end else begin
      write_done <= 1'b0;
      line_out   <= 1'b0;
      if (reset_seen && state != ST_PRES) begin
        state    <= ST_WAIT;
        wait_cnt <= 18'h00000;
        line_oe  <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            line_oe <= 1'b0;
          end
          ST_WAIT: begin
            if (wait_cnt >= PRES_WAIT_CYC[17:0] - 18'h00001) begin
              state    <= ST_PRES;
              wait_cnt <= 18'h00000;
              line_oe  <= 1'b1;
            end else begin
              wait_cnt <= wait_cnt + 18'h00001;
            end
          end
          ST_PRES: begin
            if (wait_cnt >= PRES_LEN_CYC[17:0] - 18'h00001) begin
              state       <= ST_CMD;
              line_oe     <= 1'b0;
              bit_cnt     <= 4'h0;
              bad_command <= 1'b0;
            end else begin
              wait_cnt <= wait_cnt + 18'h00001;
            end
          end
          ST_CMD: begin
            if (slot_done) begin
              cmd     <= {line_in, cmd[7:1]};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == CMD_LAST_W[3:0]) begin
                bit_cnt <= 4'h0;
                case ({line_in, cmd[7:1]})
                  `CMD_WRITE_NDIV: begin
                    state      <= ST_DATA;
                    read_dir   <= 1'b0;
                    sel_option <= 1'b0;
                  end
                  `CMD_READ_NDIV: begin
                    state      <= ST_DATA;
                    read_dir   <= 1'b1;
                    sel_option <= 1'b0;
                    data       <= n_divisor_setting;
                  end
                  `CMD_WRITE_OPTION: begin
                    state      <= ST_DATA;
                    read_dir   <= 1'b0;
                    sel_option <= 1'b1;
                  end
                  `CMD_READ_OPTION: begin
                    state      <= ST_DATA;
                    read_dir   <= 1'b1;
                    sel_option <= 1'b1;
                    data       <= option_setting;
                  end
                  default: begin
                    // Unknown codes are ignored until the next reset.
                    state       <= ST_DONE;
                    bad_command <= 1'b1;
                  end
                endcase
              end
            end
          end
          ST_DATA: begin
            if (read_dir) begin
              line_oe <= (slot_go || slot_busy) && !slot_done && !data[0];
              if (slot_done) begin
                line_oe <= 1'b0;
                data    <= {1'b0, data[8:1]};
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == DATA_LAST_W[3:0])
                  state <= ST_DONE;
              end
            end else if (slot_done) begin
              data    <= next_data;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == DATA_LAST_W[3:0]) begin
                state      <= ST_DONE;
                write_done <= 1'b1;
                if (sel_option)
                  option_setting    <= next_data;
                else
                  n_divisor_setting <= next_data;
              end
            end
          end
          ST_DONE: begin
            line_oe <= 1'b0;
          end
          default: begin
            state   <= ST_IDLE;
            line_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // single_wire_config_port

`default_nettype wire

// ===== test/wire_cfg_checker.sv
// Assertions on the ports of the single-wire configuration port.
// Assumes it is bound into the port module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wire_cfg_checker #(
  parameter RESET_MIN_CYC = 24000,
  parameter PRES_WAIT_CYC = 1500,
  parameter PRES_LEN_CYC  = 6000
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       line_in,
  input wire logic       line_out,
  input wire logic       line_oe,
  input wire logic [8:0] n_divisor_setting,
  input wire logic [8:0] option_setting,
  input wire logic       write_done,
  input wire logic       bad_command
);
  localparam int PW  = PRES_WAIT_CYC;
  localparam int PW2 = PRES_WAIT_CYC + 2;
  int low_cnt;  // Cycles the master alone has held the line low.
  int oe_cnt;   // Cycles the device has held the line low.
  // Counters let long holds be checked without huge repetitions.
  always @(posedge clk) begin
    low_cnt <= (line_in || line_oe) ? 0 : low_cnt + 1;
    oe_cnt  <= line_oe ? oe_cnt + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_line_low_only: assert property (line_out == 1'b0)
    else $error("device drove the line high");
  a_reset_values: assert property ($rose(rst_n) |-> n_divisor_setting == 9'h000
    && option_setting == 9'h034 && !line_oe && !bad_command) else $error("bad reset state");
  a_presence_after_reset: assert property ($rose(line_in) && !$past(line_oe)
    && low_cnt >= RESET_MIN_CYC |-> ##[PW:PW2] $rose(line_oe)) else $error("no presence");
  a_read_zero_hold: assert property ($rose(line_oe) |-> line_oe[*6])
    else $error("low drive too short");
  a_drive_bounded: assert property (oe_cnt <= PRES_LEN_CYC + 1)
    else $error("low drive too long");
  a_write_commit: assert property ($changed(n_divisor_setting)
    || $changed(option_setting) |-> ##[0:1] write_done) else $error("silent update");
  a_done_pulse: assert property (write_done |=> !write_done)
    else $error("write done too long");
  a_bad_no_write: assert property (bad_command |-> !write_done)
    else $error("write after bad command");
  c_presence: cover property ($rose(line_oe));
  c_write: cover property (write_done);
  c_bad: cover property ($rose(bad_command));
endmodule // wire_cfg_checker
bind single_wire_config_port wire_cfg_checker #(.RESET_MIN_CYC(RESET_MIN_CYC),
  .PRES_WAIT_CYC(PRES_WAIT_CYC), .PRES_LEN_CYC(PRES_LEN_CYC)) chk_u (.clk(clk),
  .rst_n(rst_n), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
  .n_divisor_setting(n_divisor_setting), .option_setting(option_setting),
  .write_done(write_done), .bad_command(bad_command));
`default_nettype wire

// ===== test/wire_master.sv
// Bus master model that opens every slot on the shared line.
// Assumes line_in is the resolved wire with a pull-up to high.
`timescale 1ns/1ps
`default_nettype none
module wire_master #(
  parameter SLOT_CYC = 8,
  parameter RST_LOW  = 20
) (
  input  wire logic clk,
  input  wire logic line_in,
  output var logic  pull
);
  initial pull = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic init(output logic seen);
    int i;
    seen = 1'b0;
    pull = 1'b1;
    tick(RST_LOW);
    pull = 1'b0;
    for (i = 0; i < 40 && !seen; i++) begin
      tick(1);
      seen = !line_in;
    end
    for (i = 0; i < 40 && !line_in; i++) tick(1);
    tick(2);
  endtask
  // open drain slot start
  // A zero stays short of a reset pulse yet past the sample point.
  task automatic wbit(input logic b);
    pull = 1'b1;
    tick(b ? 1 : SLOT_CYC + 4);
    pull = 1'b0;
    tick(b ? SLOT_CYC + 5 : 3);
  endtask
  task automatic rbit(output logic b);
    pull = 1'b1;
    tick(2);
    pull = 1'b0;
    tick(3);
    b = line_in;
    tick(SLOT_CYC + 2);
  endtask
endmodule // wire_master
`default_nettype wire

// ===== test/single_wire_config_port_tb.sv
// Self-checking bench for the single-wire configuration port.
// Assumes the master model and the bound checker beside it.
`timescale 1ns/1ps
`default_nettype none
module single_wire_config_port_tb;
  logic       clk, rst_n, line_oe, line_out, pull, write_done, bad_command, seen;
  logic [8:0] n_divisor_setting, option_setting, rd;
  int         errors, n_tests, cyc, writes;
  // Pull-up gives the high level whenever nobody drives low.
  wire logic  line_in = (line_oe ? line_out : 1'b1) & ~pull;
  single_wire_config_port #(.RESET_MIN_CYC(16), .PRES_WAIT_CYC(5), .PRES_LEN_CYC(10),
    .SLOT_CYC(8)) dut_u (.clk(clk), .rst_n(rst_n), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .n_divisor_setting(n_divisor_setting),
    .option_setting(option_setting), .write_done(write_done), .bad_command(bad_command));
  wire_master #(.SLOT_CYC(8)) mst_u (.clk(clk), .line_in(line_in),
    .pull(pull));
  task automatic summarize;
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One whole transaction: init, command lsb first, nine data bits.
  task automatic xact(input logic [7:0] cmd, input logic [8:0] wd, input logic [8:0] exp);
    int i;
    mst_u.init(seen);
    check("presence", 9'h001, {8'h00, seen});
    for (i = 0; i < 8; i++) mst_u.wbit(cmd[i]);
    for (i = 0; i < 9; i++) begin
      if (cmd[7]) mst_u.rbit(rd[i]);
      else mst_u.wbit(wd[i]);
    end
    if (cmd[7]) check("read data", exp, rd);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // A hang is cut short well beyond the few thousand cycles needed.
  always @(posedge clk) begin
    cyc++;
    // Each committed write must show exactly one done pulse.
    if (write_done === 1'b1) writes++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check("divider reset", 9'h000, n_divisor_setting);
    check("option reset", 9'h034, option_setting);
    check("bypass reset", 9'h000, {8'h00, option_setting[0]});
    xact(8'hA1, 9'h000, 9'h000);
    xact(8'hA2, 9'h000, 9'h034);
    xact(8'h01, 9'h1A5, 9'h000);
    check("divider", 9'h1A5, n_divisor_setting);
    check("option kept", 9'h034, option_setting);
    xact(8'h02, 9'h0CB, 9'h000);
    check("option", 9'h0CB, option_setting);
    xact(8'hA1, 9'h000, 9'h1A5);
    xact(8'h55, 9'h1FF, 9'h000);
    check("bad command", 9'h001, {8'h00, bad_command});
    check("divider kept", 9'h1A5, n_divisor_setting);
    check("write pulses", 9'h002, writes[8:0]);
    xact(8'hA2, 9'h000, 9'h0CB);
    check("bad cleared", 9'h000, {8'h00, bad_command});
    // Power removal after programming: a mid-run reset must release the
    // line and bring back the defaults before the link is used again.
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check("line released", 9'h001, {8'h00, line_in});
    check("divider default", 9'h000, n_divisor_setting);
    check("option default", 9'h034, option_setting);
    xact(8'hA2, 9'h000, 9'h034);
    summarize();
  end
endmodule // single_wire_config_port_tb
`default_nettype wire
